// ==== hdl/bmu_pkg.sv ====
package bmu_pkg;

   localparam int unsigned BYTE_W = 8;
   localparam int unsigned BITNO_W = 3;

   // Operation codes presented by the decoder
   typedef enum logic [3:0] {
      BMU_SET = 4'h0,
      BMU_CLR = 4'h1,
      BMU_INV = 4'h2,
      BMU_TST = 4'h3,
      BMU_AND = 4'h4,
      BMU_ANDN = 4'h5,
      BMU_OR = 4'h6,
      BMU_ORN = 4'h7,
      BMU_XOR = 4'h8,
      BMU_XORN = 4'h9,
      BMU_LD = 4'hA,
      BMU_LDN = 4'hB,
      BMU_ST = 4'hC,
      BMU_STN = 4'hD
   } bmu_op_type;

   // Sequencer states
   typedef enum logic [1:0] {
      BMU_IDLE = 2'b00,
      BMU_RD = 2'b01,
      BMU_WR = 2'b10
   } bmu_state_type;

   // Request from the instruction decoder
   typedef struct packed {
      bmu_op_type op;
      logic bit_from_reg;
      logic [BITNO_W-1:0] bit_imm;
      logic [BYTE_W-1:0] bit_reg;
      logic in_memory;
      logic [15:0] addr;
      logic [BYTE_W-1:0] reg_val;
   } bmu_req_type;

   // Memory bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [BYTE_W-1:0] wdata;
   } bmu_mem_type;

   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] ADDR_ZERO = 16'h0000;

endpackage

// ==== hdl/bmu_unit.sv ====
`timescale 1ns/1ps
module bmu_unit #(
   parameter int unsigned DATA_W = bmu_pkg::BYTE_W,
   parameter int unsigned BITNO_W = bmu_pkg::BITNO_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire bmu_pkg::bmu_req_type req,
   input wire logic carry_in,
   input wire logic zero_in,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output logic busy_r,
   output logic done_r,
   output logic reg_we_r,
   output logic [7:0] reg_wdata_r,
   output logic carry_r,
   output logic zero_r,
   output logic flag_we_r,
   output bmu_pkg::bmu_mem_type mem_r
);

   bmu_pkg::bmu_state_type state_r;
   bmu_pkg::bmu_op_type op_r;
   logic [2:0] bitno_r;
   logic [15:0] addr_r;
   logic cin_r;
   logic zin_r;
   logic [2:0] bitno_nxt;

   // Carrier structs fix the byte width, so only the documented sizes can be served
   if (DATA_W != bmu_pkg::BYTE_W || (1 << BITNO_W) != DATA_W) begin : g_width_check
      $error("bit manipulation unit serves byte operands only");
   end

   // One-hot mask, bit 0 is the LSB
   function automatic logic [7:0] bit_mask(input logic [2:0] n);
      bit_mask = 8'h01 << n;
   endfunction

   function automatic logic is_write_op(input bmu_pkg::bmu_op_type o);
      is_write_op = (o == bmu_pkg::BMU_SET) || (o == bmu_pkg::BMU_CLR) || (o == bmu_pkg::BMU_INV)
         || (o == bmu_pkg::BMU_ST) || (o == bmu_pkg::BMU_STN);
   endfunction

   function automatic logic [7:0] modify(input bmu_pkg::bmu_op_type o, input logic [7:0] d,
                                         input logic [2:0] n, input logic c);
      logic [7:0] m;
      m = bit_mask(n);
      case (o)
         bmu_pkg::BMU_SET: modify = d | m;
         bmu_pkg::BMU_CLR: modify = d & ~m;
         bmu_pkg::BMU_INV: modify = d ^ m;
         bmu_pkg::BMU_ST: modify = c ? (d | m) : (d & ~m);
         bmu_pkg::BMU_STN: modify = c ? (d & ~m) : (d | m);
         default: modify = d;
      endcase
   endfunction

   function automatic logic new_carry(input bmu_pkg::bmu_op_type o, input logic c, input logic b);
      case (o)
         bmu_pkg::BMU_AND: new_carry = c & b;
         bmu_pkg::BMU_ANDN: new_carry = c & ~b;
         bmu_pkg::BMU_OR: new_carry = c | b;
         bmu_pkg::BMU_ORN: new_carry = c | ~b;
         bmu_pkg::BMU_XOR: new_carry = c ^ b;
         bmu_pkg::BMU_XORN: new_carry = c ^ ~b;
         bmu_pkg::BMU_LD: new_carry = b;
         bmu_pkg::BMU_LDN: new_carry = ~b;
         default: new_carry = c;
      endcase
   endfunction

   function automatic logic is_inverted(input bmu_pkg::bmu_op_type o);
      is_inverted = (o == bmu_pkg::BMU_ANDN) || (o == bmu_pkg::BMU_ORN) || (o == bmu_pkg::BMU_XORN)
         || (o == bmu_pkg::BMU_LDN) || (o == bmu_pkg::BMU_STN);
   endfunction

   function automatic logic reg_bit_ok(input bmu_pkg::bmu_op_type o);
      reg_bit_ok = (o == bmu_pkg::BMU_SET) || (o == bmu_pkg::BMU_CLR) || (o == bmu_pkg::BMU_INV)
         || (o == bmu_pkg::BMU_TST);
   endfunction

   // Register bit number only for set/clear/invert/test
   // Inverted and other forms always take the immediate
   always_comb begin
      if (req.bit_from_reg && reg_bit_ok(req.op)) begin
         bitno_nxt = req.bit_reg[2:0];
      end else begin
         bitno_nxt = req.bit_imm;
      end
   end

   // Result stage shared by register and memory paths
   logic [7:0] operand;
   logic finish;
   assign operand = (state_r == bmu_pkg::BMU_RD) ? mem_rdata : req.reg_val;
   assign finish = (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory)
      || (state_r == bmu_pkg::BMU_RD && mem_ack);

   bmu_pkg::bmu_op_type fin_op;
   logic [2:0] fin_bit;
   logic fin_c;
   logic fin_z;
   assign fin_op = (state_r == bmu_pkg::BMU_IDLE) ? req.op : op_r;
   assign fin_bit = (state_r == bmu_pkg::BMU_IDLE) ? bitno_nxt : bitno_r;
   assign fin_c = (state_r == bmu_pkg::BMU_IDLE) ? carry_in : cin_r;
   assign fin_z = (state_r == bmu_pkg::BMU_IDLE) ? zero_in : zin_r;

   // Sequencer; a memory write waits on its own ack so the bus never sees two requests
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= bmu_pkg::BMU_IDLE;
         op_r <= bmu_pkg::BMU_SET;
         bitno_r <= 3'h0;
         addr_r <= bmu_pkg::ADDR_ZERO;
         cin_r <= 1'b0;
         zin_r <= 1'b0;
      end else begin
         case (state_r)
            bmu_pkg::BMU_IDLE: begin
               if (req_valid) begin
                  op_r <= req.op;
                  bitno_r <= bitno_nxt;
                  addr_r <= req.addr;
                  cin_r <= carry_in;
                  zin_r <= zero_in;
                  if (req.in_memory) begin
                     state_r <= bmu_pkg::BMU_RD;
                  end
               end
            end
            // Byte read, then write-back to same address for set/clear/invert/store ops
            bmu_pkg::BMU_RD: begin
               if (mem_ack) begin
                  state_r <= is_write_op(op_r) ? bmu_pkg::BMU_WR : bmu_pkg::BMU_IDLE;
               end
            end
            bmu_pkg::BMU_WR: begin
               if (mem_ack) begin
                  state_r <= bmu_pkg::BMU_IDLE;
               end
            end
            default: state_r <= bmu_pkg::BMU_IDLE;
         endcase
      end
   end

   // Memory bus drive
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_r <= '0;
      end else begin
         if (state_r == bmu_pkg::BMU_IDLE && req_valid && req.in_memory) begin
            mem_r.rd <= 1'b1;
            mem_r.addr <= req.addr;
         end else if (state_r == bmu_pkg::BMU_RD && mem_ack) begin
            mem_r.rd <= 1'b0;
            if (is_write_op(op_r)) begin
               mem_r.wr <= 1'b1;
               mem_r.addr <= addr_r;
               mem_r.wdata <= modify(op_r, mem_rdata, bitno_r, cin_r);
            end
         end else if (state_r == bmu_pkg::BMU_WR && mem_ack) begin
            mem_r.wr <= 1'b0;
         end
      end
   end

   // Register result and flags
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_we_r <= 1'b0;
         reg_wdata_r <= bmu_pkg::BYTE_ZERO;
         flag_we_r <= 1'b0;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
      end else begin
         reg_we_r <= finish && is_write_op(fin_op) && state_r == bmu_pkg::BMU_IDLE;
         reg_wdata_r <= modify(fin_op, operand, fin_bit, fin_c);
         flag_we_r <= finish && !is_write_op(fin_op);
         if (finish) begin
            carry_r <= new_carry(fin_op, fin_c, operand[fin_bit]);
            // Z set when tested bit is zero, operand untouched
            zero_r <= (fin_op == bmu_pkg::BMU_TST) ? ~operand[fin_bit] : fin_z;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         busy_r <= (state_r == bmu_pkg::BMU_IDLE) ? (req_valid && req.in_memory)
            : !(state_r == bmu_pkg::BMU_WR && mem_ack)
              && !(state_r == bmu_pkg::BMU_RD && mem_ack && !is_write_op(op_r));
         done_r <= finish && !(state_r == bmu_pkg::BMU_RD && is_write_op(op_r))
            || (state_r == bmu_pkg::BMU_WR && mem_ack);
      end
   end

   // Assertions
   // Set forces bit
   a_set_bit_high: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_SET)
      |=> reg_we_r && reg_wdata_r == ($past(req.reg_val) | bit_mask($past(bitno_nxt))))
      else $error("set-bit result wrong");
   a_clr_bit_low: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_CLR)
      |=> reg_wdata_r == ($past(req.reg_val) & ~bit_mask($past(bitno_nxt))))
      else $error("clear-bit result wrong");
   a_inv_bit_flip: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_INV)
      |=> reg_wdata_r == ($past(req.reg_val) ^ bit_mask($past(bitno_nxt))))
      else $error("invert-bit changed wrong bits");
   a_tst_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_TST)
      |=> flag_we_r && !reg_we_r && zero_r == !$past(req.reg_val[bitno_nxt]))
      else $error("test-bit zero flag wrong");
   a_tst_no_write: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_RD && mem_ack && op_r == bmu_pkg::BMU_TST)
      |=> !mem_r.wr && !reg_we_r)
      else $error("test-bit wrote its operand");
   a_inv_imm_bit: assert property (@(posedge mclk) disable iff (!rst_n)
      is_inverted(req.op) |-> bitno_nxt == req.bit_imm)
      else $error("inverted op used register bit number");
   a_reg_bit_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      (req.bit_from_reg && req.op == bmu_pkg::BMU_TST) |-> bitno_nxt == req.bit_reg[2:0])
      else $error("register bit number ignored");
   a_ld_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_LD)
      |=> carry_r == $past(req.reg_val[bitno_nxt]))
      else $error("bit load carry wrong");
   a_ldn_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_LDN)
      |=> carry_r == !$past(req.reg_val[bitno_nxt]))
      else $error("inverted bit load carry wrong");
   a_and_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_AND)
      |=> carry_r == ($past(carry_in) & $past(req.reg_val[bitno_nxt])))
      else $error("carry AND wrong");
   a_andn_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_ANDN)
      |=> carry_r == ($past(carry_in) & !$past(req.reg_val[bitno_nxt])))
      else $error("carry AND inverted wrong");
   a_or_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_OR)
      |=> carry_r == ($past(carry_in) | $past(req.reg_val[bitno_nxt])))
      else $error("carry OR wrong");
   a_orn_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_ORN)
      |=> carry_r == ($past(carry_in) | !$past(req.reg_val[bitno_nxt])))
      else $error("carry OR inverted wrong");
   a_xor_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_XOR)
      |=> carry_r == ($past(carry_in) ^ $past(req.reg_val[bitno_nxt])))
      else $error("carry XOR wrong");
   a_xorn_carry: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_XORN)
      |=> carry_r == ($past(carry_in) ^ !$past(req.reg_val[bitno_nxt])))
      else $error("carry XOR inverted wrong");
   a_st_bit: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_ST)
      |=> reg_we_r && reg_wdata_r[$past(bitno_nxt)] == $past(carry_in)
         && $countones(reg_wdata_r ^ $past(req.reg_val)) <= 1)
      else $error("bit store wrong");
   a_stn_bit: assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == bmu_pkg::BMU_IDLE && req_valid && !req.in_memory && req.op == bmu_pkg::BMU_STN)
      |=> reg_we_r && reg_wdata_r[$past(bitno_nxt)] == !$past(carry_in)
         && $countones(reg_wdata_r ^ $past(req.reg_val)) <= 1)
      else $error("inverted bit store wrong");
   a_mem_rmw_addr: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(mem_r.wr) |-> mem_r.addr == addr_r && $past(state_r) == bmu_pkg::BMU_RD)
      else $error("write-back address or order wrong");
   a_mem_one_bit: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(mem_r.wr) |-> $countones(mem_r.wdata ^ $past(mem_rdata)) <= 1)
      else $error("write-back changed more than one bit");
   c_mem_rmw: cover property (@(posedge mclk) disable iff (!rst_n) $rose(mem_r.wr));
   c_reg_set: cover property (@(posedge mclk) disable iff (!rst_n) reg_we_r);
   c_test_op: cover property (@(posedge mclk) disable iff (!rst_n) flag_we_r && zero_r);
   // Request arriving mid operation is dropped
   c_busy_req: cover property (@(posedge mclk) disable iff (!rst_n) busy_r && req_valid);

endmodule // bmu_unit

// ==== tb/bmu_mem_model.sv ====
`timescale 1ns/1ps
module bmu_mem_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] lat,
   input wire bmu_pkg::bmu_mem_type mem,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem_a [0:255];
   logic [7:0] rdata_r;
   logic [3:0] wait_r;
   // Released bus shows the inverse of the last byte, so a stale sample is caught
   assign mem_rdata = mem_ack ? rdata_r : ~rdata_r;
   // Ack never in the cycle the strobe rises; lat stretches the wait
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         wait_r <= 4'h0;
         rdata_r <= 8'h00;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         wait_r <= 4'h0;
      end else if (mem.rd || mem.wr) begin
         if (wait_r < lat) begin
            wait_r <= wait_r + 4'h1;
         end else begin
            mem_ack <= 1'b1;
            if (mem.rd) rdata_r <= mem_a[mem.addr[7:0]];
            if (mem.wr) mem_a[mem.addr[7:0]] <= mem.wdata;
         end
      end
   end
endmodule // bmu_mem_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic mclk, rst_n, req_valid, carry_in, zero_in, mem_ack;
   logic busy_r, done_r, reg_we_r, carry_r, zero_r, flag_we_r;
   logic [7:0] mem_rdata, reg_wdata_r;
   logic [3:0] lat;
   bmu_pkg::bmu_req_type req;
   bmu_pkg::bmu_mem_type mem_r;
   int errors, comparisons;
   bmu_unit bmu_unit_i (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .carry_in(carry_in),
      .zero_in(zero_in), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy_r(busy_r), .done_r(done_r),
      .reg_we_r(reg_we_r), .reg_wdata_r(reg_wdata_r), .carry_r(carry_r), .zero_r(zero_r),
      .flag_we_r(flag_we_r), .mem_r(mem_r));
   bmu_mem_model bmu_mem_model_i (.mclk(mclk), .rst_n(rst_n), .lat(lat), .mem(mem_r), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic wrap_up();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Expected {writes byte, carry, zero, byte}
   function automatic logic [10:0] expect_fn(bmu_pkg::bmu_op_type op, logic [7:0] v, logic [2:0] n, logic c,
         logic z);
      logic [7:0] b;
      logic cc, zz;
      b = v;
      cc = c;
      zz = z;
      case (op)
         bmu_pkg::BMU_SET: b[n] = 1'b1;
         bmu_pkg::BMU_CLR: b[n] = 1'b0;
         bmu_pkg::BMU_INV: b[n] = ~v[n];
         bmu_pkg::BMU_TST: zz = ~v[n];
         bmu_pkg::BMU_AND: cc = c & v[n];
         bmu_pkg::BMU_ANDN: cc = c & ~v[n];
         bmu_pkg::BMU_OR: cc = c | v[n];
         bmu_pkg::BMU_ORN: cc = c | ~v[n];
         bmu_pkg::BMU_XOR: cc = c ^ v[n];
         bmu_pkg::BMU_XORN: cc = c ^ ~v[n];
         bmu_pkg::BMU_LD: cc = v[n];
         bmu_pkg::BMU_LDN: cc = ~v[n];
         bmu_pkg::BMU_ST: b[n] = c;
         default: b[n] = ~c;
      endcase
      return {(op <= bmu_pkg::BMU_INV) || (op >= bmu_pkg::BMU_ST), cc, zz, b};
   endfunction
   // One request; hold keeps req_valid up one extra cycle while busy
   task automatic do_op(input bmu_pkg::bmu_op_type op, input logic rg, input logic [7:0] breg,
         input logic [2:0] imm, input logic in_mem, input logic [7:0] v, input logic c, input logic z,
         input logic hold);
      logic [10:0] e;
      int i;
      e = expect_fn(op, v, (rg && op <= bmu_pkg::BMU_TST) ? breg[2:0] : imm, c, z);
      if (in_mem) bmu_mem_model_i.mem_a[8'h40] = v;
      @(posedge mclk);
      req_valid <= 1'b1;
      // Register copy differs from memory so a wrong operand source shows
      req <= '{op, rg, imm, breg, in_mem, 16'h1240, in_mem ? ~v : v};
      carry_in <= c;
      zero_in <= z;
      for (i = 0; i < 40; i++) begin
         @(posedge mclk);
         if (i > 0 || !hold) req_valid <= 1'b0;
         #1;
         if (done_r === 1'b1) break;
      end
      if (i == 40) begin
         chk(1'b0, "no done");
         wrap_up();
      end else begin
         chk(reg_we_r === (e[10] && !in_mem), "register write strobe");
         if (e[10] && !in_mem) chk(reg_wdata_r === e[7:0], "register byte");
         chk(flag_we_r === !e[10], "flag strobe");
         if (!e[10]) chk({carry_r, zero_r} === e[9:8], "flags");
         if (in_mem) chk(bmu_mem_model_i.mem_a[8'h40] === e[7:0], "memory byte");
      end
   endtask
   task automatic reset_idle();
      chk({busy_r, done_r, reg_we_r, flag_we_r, mem_r.rd, mem_r.wr} === 6'h00, "outputs idle in reset");
   endtask
   // Every op, bit position and bit-number source on a register operand
   task automatic reg_sweep();
      for (int n = 0; n < 8; n++)
         for (int op = 0; op < 14; op++)
            for (int r = 0; r < 2; r++)
               do_op(bmu_pkg::bmu_op_type'(op), r[0], {5'h1B, 3'(n)}, r[0] ? ~3'(n) : 3'(n), 1'b0,
                  8'(n * 37 + op * 11 + r * 5), n[1] ^ r[0], n[0] ^ r[0], 1'b0);
   endtask
   // Every op on a memory byte, prompt and slow memory
   task automatic mem_sweep();
      for (int l = 0; l < 4; l += 3) begin
         lat <= 4'(l);
         for (int op = 0; op < 14; op++)
            do_op(bmu_pkg::bmu_op_type'(op), 1'b0, 8'hFF, 3'(op + l), 1'b1, 8'h3C ^ 8'(op * 7), op[1], op[2],
               1'b0);
      end
   endtask
   // A second invert taken while busy would restore the byte
   task automatic busy_ignored();
      lat <= 4'h2;
      do_op(bmu_pkg::BMU_INV, 1'b0, 8'h00, 3'h5, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b1);
   endtask
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      carry_in = 1'b0;
      zero_in = 1'b0;
      lat = 4'h0;
      errors = 0;
      comparisons = 0;
      repeat (16) @(posedge mclk);
      #1;
      reset_idle();
      @(posedge mclk);
      rst_n <= 1'b1;
      reg_sweep();
      mem_sweep();
      busy_ignored();
      wrap_up();
   end
endmodule // tb
